// *** hdl/setpoint_regs.vh ***
// Constants for the setpoint batch sequencer
`ifndef SETPOINT_REGS_VH
`define SETPOINT_REGS_VH
`define SP_COUNT 20
`define SP_IDX_W 5
`define SP_VAL_W 32
// Register map: word address selects field, index in upper bits
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SP_BASE 12'h100
// Per setpoint: base + idx*16 + field*4
`define SP_FLD_KIND 2'h0
`define SP_FLD_VALUE 2'h1
`define SP_FLD_SRC 2'h2
`define SP_FLD_PERC 2'h3
// Control bits
`define CTRL_BATCH_MANUAL 0
`define CTRL_SPEED_PLC 1
`define CTRL_PERMIT_ASSIGNED 2
`define CTRL_START_CMD 4
`define CTRL_HOLD_CMD 5
`define CTRL_REWIND_CMD 6
`define CTRL_STOP_CMD 7
// Kind encodings
`define KIND_OFF 4'h0
`define KIND_RATE 4'h1
`define KIND_PRATE 4'h2
`define KIND_LOAD 4'h3
`define KIND_SPEED 4'h4
`define KIND_TOTAL 4'h5
`define KIND_MV 4'h6
`define KIND_PAUSE 4'h7
`define KIND_DELAY 4'h8
// Kind register layout
`define KF_TRIP_HIGHER 4
`define KF_BATCH_SEQ 5
// Timing
`define CLK_HZ 20000000
`define TENTH_NS 100000000
`define TENTH_CYCLES (`TENTH_NS / 50)
`endif

// *** hdl/setpoint_compare.v ***
// Single setpoint comparison against the selected measurement
`timescale 1ns/1ns
`include "setpoint_regs.vh"
module setpoint_compare #(
  parameter W = 32
) (
  input wire [3:0] kind_i,
  input wire trip_higher_i,
  input wire [W-1:0] value_i,
  input wire [W-1:0] rate_i,
  input wire [W-1:0] load_i,
  input wire [W-1:0] speed_i,
  input wire [W-1:0] total_i,
  input wire [W-1:0] mv_i,
  input wire [W-1:0] max_cap_i,
  output reg met_o
);
  reg [W-1:0] meas;
  reg [W-1:0] ref_v;
  reg [2*W-1:0] prod;
  always @* begin
    prod = value_i * max_cap_i;
    ref_v = value_i;
    meas = {W{1'b0}};
    case (kind_i)
      `KIND_RATE: meas = rate_i;
      `KIND_PRATE: begin
        meas = rate_i;
        ref_v = prod[W-1:0] / 100;
      end
      `KIND_LOAD: meas = load_i;
      `KIND_SPEED: meas = speed_i;
      `KIND_TOTAL: meas = total_i;
      `KIND_MV: meas = mv_i;
      default: meas = {W{1'b0}};
    endcase
    if (kind_i == `KIND_OFF || kind_i > `KIND_MV)
      met_o = 1'b0;
    else if (trip_higher_i)
      met_o = meas > ref_v;
    else
      met_o = meas < ref_v;
  end
endmodule // setpoint_compare

// *** hdl/setpoint_batch_sequencer.v ***
// Setpoint engine with continuous and batch setpoints
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "setpoint_regs.vh"
module setpoint_batch_sequencer #(
  parameter N = `SP_COUNT,
  parameter W = `SP_VAL_W,
  parameter TENTH_CYC = `TENTH_CYCLES
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire clk_en_i,
  input wire [`ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire sample_i,
  input wire [W-1:0] rate_i,
  input wire [W-1:0] load_i,
  input wire [W-1:0] speed_i,
  input wire [W-1:0] total0_i,
  input wire [W-1:0] total1_i,
  input wire [W-1:0] mv_i,
  input wire [W-1:0] max_cap_i,
  input wire sequence_start_request_n_i,
  input wire run_permit_input_n_i,
  input wire hold_input_n_i,
  input wire rewind_input_n_i,
  output reg [N-1:0] sp_out_o,
  output reg batch_running_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_STOP = 2'd2;
  localparam ST_PAUSE = 2'd3;

  // Three-stage pin synchronisers, edge counted when stages 2 and 3 agree
  // Stages reset to the idle high pin level so no false edge follows reset
  reg [2:0] s_start, s_permit, s_hold, s_rewind;
  reg start_lvl, permit_lvl, hold_lvl, rewind_lvl;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_start <= 3'b111;
      s_permit <= 3'b111;
      s_hold <= 3'b111;
      s_rewind <= 3'b111;
      start_lvl <= 1'b0;
      permit_lvl <= 1'b0;
      hold_lvl <= 1'b0;
      rewind_lvl <= 1'b0;
    end else if (clk_en_i) begin
      s_start <= {s_start[1:0], sequence_start_request_n_i};
      s_permit <= {s_permit[1:0], run_permit_input_n_i};
      s_hold <= {s_hold[1:0], hold_input_n_i};
      s_rewind <= {s_rewind[1:0], rewind_input_n_i};
      if (s_start[1] == s_start[2]) start_lvl <= ~s_start[2];
      if (s_permit[1] == s_permit[2]) permit_lvl <= ~s_permit[2];
      if (s_hold[1] == s_hold[2]) hold_lvl <= ~s_hold[2];
      if (s_rewind[1] == s_rewind[2]) rewind_lvl <= ~s_rewind[2];
    end
  end
  reg start_lvl_d, rewind_lvl_d;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_lvl_d <= 1'b0;
      rewind_lvl_d <= 1'b0;
    end else if (clk_en_i) begin
      start_lvl_d <= start_lvl;
      rewind_lvl_d <= rewind_lvl;
    end
  end

  // Configuration registers
  reg [7:0] ctrl;
  reg [7:0] sp_kind [0:N-1];
  reg [W-1:0] sp_value [0:N-1];
  reg [N-1:0] sp_src;
  wire [`ADDR_W-1:0] sp_off = addr_i - `REG_SP_BASE;
  wire [4:0] sp_sel = sp_off[8:4];
  wire [1:0] sp_fld = sp_off[3:2];
  // Only the slots that exist decode; higher addresses must not alias onto them
  wire sp_hit = addr_i >= `REG_SP_BASE && sp_off[`ADDR_W-1:9] == 3'b000 && sp_sel < N;
  wire sp_wr = wr_i && sp_hit;
  wire ctrl_wr = wr_i && addr_i == `REG_CTRL;
  wire start_cmd = ctrl_wr && wdata_i[`CTRL_START_CMD];
  wire hold_cmd = ctrl_wr && wdata_i[`CTRL_HOLD_CMD];
  wire rewind_cmd = ctrl_wr && wdata_i[`CTRL_REWIND_CMD];
  wire stop_cmd = ctrl_wr && wdata_i[`CTRL_STOP_CMD];
  integer k;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= 8'h00;
      sp_src <= {N{1'b0}};
      for (k = 0; k < N; k = k + 1) begin
        sp_kind[k] <= 8'h00;
        sp_value[k] <= {W{1'b0}};
      end
    end else if (clk_en_i) begin
      if (ctrl_wr)
        ctrl <= {4'h0, wdata_i[3:0]};
      if (sp_wr) begin
        if (sp_fld == `SP_FLD_KIND) sp_kind[sp_sel] <= wdata_i[7:0];
        if (sp_fld == `SP_FLD_VALUE) sp_value[sp_sel] <= wdata_i[W-1:0];
        if (sp_fld == `SP_FLD_SRC) sp_src[sp_sel] <= wdata_i[0];
      end
    end
  end
  wire manual = ctrl[`CTRL_BATCH_MANUAL];
  wire assigned = ctrl[`CTRL_PERMIT_ASSIGNED];
  // An unassigned permit input never blocks a batch
  wire permit_ok = !assigned || permit_lvl;

  // Pause and delay exist only as batch steps
  function batch_only;
    input [3:0] kind;
    begin
      batch_only = kind == `KIND_PAUSE || kind == `KIND_DELAY;
    end
  endfunction

  // Comparators, one per setpoint
  wire [N-1:0] met;
  wire [N-1:0] avail;
  wire [N-1:0] in_batch;
  wire [N-1:0] is_cont;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_sp
      wire [3:0] knd = sp_kind[g][3:0];
      wire only_batch = batch_only(knd);
      assign avail[g] = !(g == N-1 && ctrl[`CTRL_SPEED_PLC]);
      assign in_batch[g] = avail[g] && manual &&
        (only_batch || (knd != `KIND_OFF && sp_kind[g][`KF_BATCH_SEQ]));
      assign is_cont[g] = avail[g] && !only_batch && knd != `KIND_OFF &&
        !(manual && sp_kind[g][`KF_BATCH_SEQ]);
      setpoint_compare #(.W(W)) u_cmp (
        .kind_i(knd),
        .trip_higher_i(sp_kind[g][`KF_TRIP_HIGHER]),
        .value_i(sp_value[g]),
        .rate_i(rate_i),
        .load_i(load_i),
        .speed_i(speed_i),
        .total_i(sp_src[g] ? total1_i : total0_i),
        .mv_i(mv_i),
        .max_cap_i(max_cap_i),
        .met_o(met[g])
      );
    end
  endgenerate

  // Next enabled batch step at or after position p
  function [5:0] next_step;
    input [N-1:0] mask;
    input [4:0] p;
    integer i;
    begin
      next_step = 6'h3f;
      for (i = N-1; i >= 0; i = i - 1)
        if (mask[i] && i >= p) next_step = i[5:0];
    end
  endfunction

  // Batch sequencer
  reg [1:0] state;
  reg [4:0] step;
  reg [N-1:0] done;
  reg [31:0] tick;
  reg [W-1:0] tenths;
  reg cmd_hold;
  wire start_ev = (start_lvl && !start_lvl_d) || start_cmd;
  // Pin and command paths merge; each request acts once
  wire rewind_ev = (rewind_lvl && !rewind_lvl_d) || rewind_cmd;
  wire [5:0] first = next_step(in_batch, 5'd0);
  wire [3:0] cur_kind = sp_kind[step][3:0];
  wire [5:0] after = (step == N-1) ? 6'h3f : next_step(in_batch, step + 5'd1);
  // Hold pin low pauses the step and drops its output; release resumes it
  wire held = hold_lvl;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      step <= 5'd0;
      done <= {N{1'b0}};
      tick <= 32'h0000_0000;
      tenths <= {W{1'b0}};
      cmd_hold <= 1'b0;
    end else if (clk_en_i) begin
      if (!manual || rewind_ev || (start_ev && !permit_ok)) begin
        state <= ST_IDLE;
        step <= 5'd0;
        done <= {N{1'b0}};
        tick <= 32'h0000_0000;
        tenths <= {W{1'b0}};
        cmd_hold <= 1'b0;
      end else if (state == ST_RUN && (!permit_ok || stop_cmd)) begin
        state <= ST_STOP;
      end else if (state == ST_RUN && hold_cmd) begin
        state <= ST_PAUSE;
        cmd_hold <= 1'b1;
      end else if (start_ev) begin
        if (state == ST_IDLE) begin
          if (first != 6'h3f) begin
            step <= first[4:0];
            state <= ST_RUN;
            done <= {N{1'b0}};
          end
        end else if (state == ST_PAUSE && cur_kind == `KIND_PAUSE && !cmd_hold) begin
          state <= ST_RUN;
          step <= after[4:0];
          if (after == 6'h3f) state <= ST_IDLE;
        end else begin
          state <= ST_RUN;
          cmd_hold <= 1'b0;
        end
      end else if (state == ST_RUN && !held) begin
        if (cur_kind == `KIND_PAUSE) begin
          state <= ST_PAUSE;
        end else if (cur_kind == `KIND_DELAY) begin
          // Timer state survives a stop, so a resumed delay only runs out its rest
          if (tenths >= sp_value[step]) begin
            tenths <= {W{1'b0}};
            tick <= 32'h0000_0000;
            step <= after[4:0];
            if (after == 6'h3f) state <= ST_IDLE;
          end else if (tick >= TENTH_CYC - 1) begin
            tick <= 32'h0000_0000;
            tenths <= tenths + 1'b1;
          end else begin
            tick <= tick + 1'b1;
          end
        end else if (sample_i && met[step]) begin
          done[step] <= 1'b1;
          step <= after[4:0];
          if (after == 6'h3f) state <= ST_IDLE;
        end
      end
    end
  end

  // Outputs: continuous follow at each sample, batch step drives while active
  // Continuous outputs lag a sample by two cycles: cont_q, then the output flop
  reg [N-1:0] cont_q;
  integer j;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cont_q <= {N{1'b0}};
      sp_out_o <= {N{1'b0}};
      batch_running_o <= 1'b0;
    end else if (clk_en_i) begin
      if (sample_i)
        cont_q <= met & is_cont;
      for (j = 0; j < N; j = j + 1) begin
        if (is_cont[j])
          sp_out_o[j] <= cont_q[j];
        else
          sp_out_o[j] <= state == ST_RUN && !held && step == j &&
            !done[j] && in_batch[j] && !batch_only(sp_kind[j][3:0]);
      end
      batch_running_o <= state == ST_RUN;
    end
  end

  // Register read port, data valid the cycle after the strobe
  // Reads of unmapped addresses and of write-only bits return zero
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        if (addr_i == `REG_CTRL)
          rdata_o <= {24'h00_0000, ctrl};
        else if (addr_i == `REG_STATUS)
          rdata_o <= {cont_q[11:0], 9'h000, cmd_hold, step, 3'b000, state};
        else if (sp_hit) begin
          if (sp_fld == `SP_FLD_KIND) rdata_o <= {24'h00_0000, sp_kind[sp_sel]};
          if (sp_fld == `SP_FLD_VALUE) rdata_o <= sp_value[sp_sel];
          if (sp_fld == `SP_FLD_SRC) rdata_o <= {31'h0000_0000, sp_src[sp_sel]};
          if (sp_fld == `SP_FLD_PERC) rdata_o <= {31'h0000_0000, done[sp_sel]};
        end
      end
    end
  end
endmodule // setpoint_batch_sequencer

// *** dv/setpoint_batch_sequencer_properties.sv ***
// Port checker for the setpoint batch sequencer
`timescale 1ns/1ns
module sp_seq_checker (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire clk_en_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire sample_i,
  input wire sequence_start_request_n_i,
  input wire run_permit_input_n_i,
  input wire rewind_input_n_i,
  input wire [19:0] sp_out_o,
  input wire batch_running_o
);
  reg man;
  reg plc;
  reg asg;
  reg [3:0] since;
  wire ctrl_wr = wr_i && clk_en_i && addr_i == 12'h000;
  // Shadow of the control word, rebuilt from bus writes
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      man <= 1'b0;
      plc <= 1'b0;
      asg <= 1'b0;
      since <= 4'hf;
    end else begin
      if (ctrl_wr) begin
        man <= wdata_i[0];
        plc <= wdata_i[1];
        asg <= wdata_i[2];
      end
      if (!sequence_start_request_n_i || (ctrl_wr && wdata_i[4]))
        since <= 4'h0;
      else if (since != 4'hf)
        since <= since + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  rd_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
  plc_last_off_a: assert property (plc && $past(plc, 3) |-> !sp_out_o[19])
    else $error("setpoint twenty active with plc speed");
  cont_on_sample_a: assert property (!man && !$past(man, 4) && $changed(sp_out_o[18:0])
    |-> $past(sample_i, 2)) else $error("continuous output moved without a sample");
  manual_only_a: assert property (!man && !$past(man, 3) |-> !batch_running_o)
    else $error("batch running without manual batching");
  start_needed_a: assert property ($rose(batch_running_o) |-> since < 4'ha)
    else $error("batch began without a start request");
  permit_stop_a: assert property ((asg && run_permit_input_n_i) [*8] |-> !batch_running_o)
    else $error("batch runs with permit withdrawn");
  hold_cmd_stop_a: assert property (ctrl_wr && wdata_i[5] && !wdata_i[4]
    |-> ##3 !batch_running_o) else $error("hold command did not pause");
  rewind_stop_a: assert property ($fell(rewind_input_n_i) |-> ##7 !batch_running_o)
    else $error("rewind did not stop the batch");
  cover property ($rose(batch_running_o));
  cover property ($fell(sp_out_o[9]));
  cover property ($rose(sp_out_o[19]));
endmodule // sp_seq_checker
bind setpoint_batch_sequencer sp_seq_checker chk_i (.sys_clk_i, .nrst_i, .clk_en_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_i, .sequence_start_request_n_i, .run_permit_input_n_i,
  .rewind_input_n_i, .sp_out_o, .batch_running_o);

// *** dv/conveyor_plant.sv ***
// Conveyor plant model: converter samples and a totalizer fed by one output
`timescale 1ns/1ns
module conveyor_plant #(parameter SPAN = 8, parameter FEED = 9) (
  input wire sys_clk_i,
  input wire [19:0] sp_out_i,
  input wire [31:0] rate_i,
  output reg sample_o,
  output reg [31:0] total_o
);
  reg [3:0] cnt = 4'h0;
  initial sample_o = 1'b0;
  initial total_o = 32'h0000_0000;
  always @(posedge sys_clk_i) begin
    cnt <= (cnt == SPAN - 1) ? 4'h0 : cnt + 4'h1;
    sample_o <= (cnt == 4'h0);
    // Material only arrives while the feeder output is on
    if (sample_o && sp_out_i[FEED])
      total_o <= total_o + rate_i;
  end
endmodule // conveyor_plant

// *** dv/setpoint_batch_sequencer_tb.sv ***
// Testbench for the setpoint batch sequencer
`timescale 1ns/1ns
module setpoint_batch_sequencer_tb;
  reg sys_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [11:0] addr_i = 12'h000;
  reg [31:0] wdata_i = 32'h0000_0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [31:0] rate_i = 32'h0000_0000;
  reg [31:0] max_cap_i = 32'h0000_00c8;
  reg [3:0] pin_n = 4'b1101;
  wire [31:0] rdata_o;
  wire [31:0] total0_i;
  wire [19:0] sp_out_o;
  wire sample_i;
  wire batch_running_o;
  integer mismatches = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer k;
  setpoint_batch_sequencer #(.TENTH_CYC(20)) dut (.sys_clk_i, .nrst_i, .clk_en_i(1'b1),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_i, .rate_i, .load_i(rate_i),
    .speed_i(rate_i), .total0_i, .total1_i(32'h0000_0000), .mv_i(rate_i), .max_cap_i,
    .sequence_start_request_n_i(pin_n[0]), .run_permit_input_n_i(pin_n[1]),
    .hold_input_n_i(pin_n[2]), .rewind_input_n_i(pin_n[3]), .sp_out_o, .batch_running_o);
  conveyor_plant plant (.sys_clk_i, .sp_out_i(sp_out_o), .rate_i, .sample_o(sample_i),
    .total_o(total0_i));
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task wr(input integer a, input [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a[11:0];
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Leaves rdata_o settled in the single cycle it stands
  task rd(input integer a);
    @(posedge sys_clk_i);
    addr_i <= a[11:0];
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
  endtask
  task pulse(input integer p);
    @(posedge sys_clk_i);
    pin_n[p] <= 1'b0;
    tick(6);
    pin_n[p] <= 1'b1;
    tick(6);
  endtask
  // Bit 20 of the watched vector is the running flag
  task await(input integer b, input v);
    for (k = 0; k < 300 && ({batch_running_o, sp_out_o} >> b) % 2 !== v; k = k + 1)
      @(posedge sys_clk_i);
    chk("awaited output", ({batch_running_o, sp_out_o} >> b) % 2, v);
  endtask
  initial begin
    tick(8);
    nrst_i <= 1'b1;
    tick(2);
    for (k = 1; k < 7; k = k + 1) begin
      wr(256 + 16 * k, k == 5 ? 5 : 16 + k);
      wr(260 + 16 * k, k == 2 ? 50 : 100);
    end
    wr(560, 32'h0000_0011);
    wr(564, 32'h0000_0064);
    for (k = 0; k < 3; k = k + 1) begin
      rate_i <= k == 1 ? 150 : 50;
      tick(24);
      chk("continuous", {sp_out_o[19], sp_out_o[6:1]}, k == 1 ? 7'h7f : 7'h10);
    end
    rate_i <= 32'h0000_0096;
    wr(0, 32'h0000_0002);
    tick(24);
    chk("last setpoint", sp_out_o[19], 0);
    wr(0, 32'h0000_0001);
    wr(400, 32'h0000_0035);
    wr(404, 32'h0000_012c);
    wr(408, 32'h0000_0000);
    wr(416, 32'h0000_0008);
    wr(420, 32'h0000_0003);
    wr(432, 32'h0000_0007);
    wr(448, 32'h0000_0021);
    wr(452, 32'h0000_03e8);
    tick(24);
    chk("idle step", sp_out_o[9], 0);
    pulse(0);
    await(9, 1);
    pin_n[2] <= 1'b0;
    tick(8);
    chk("held step", sp_out_o[9], 0);
    pin_n[2] <= 1'b1;
    tick(8);
    chk("resumed step", sp_out_o[9], 1);
    await(9, 0);
    rd(4);
    chk("delay step", rdata_o[9:5], 10);
    tick(30);
    rd(4);
    chk("delay holds", rdata_o[9:5], 10);
    tick(60);
    rd(4);
    chk("pause step", rdata_o[9:5], 11);
    tick(40);
    rd(4);
    chk("pause holds", rdata_o[9:5], 11);
    chk("dual kind", sp_out_o[1], 1);
    pulse(0);
    await(20, 0);
    rd(4);
    chk("run ended", rdata_o[1:0], 0);
    chk("latched off", sp_out_o[9], 0);
    wr(0, 32'h0000_0005);
    pin_n[1] <= 1'b1;
    pulse(0);
    tick(10);
    chk("refused start", batch_running_o, 0);
    pin_n[1] <= 1'b0;
    pulse(0);
    await(20, 1);
    pin_n[1] <= 1'b1;
    tick(12);
    chk("permit stop", {batch_running_o, sp_out_o[12:9]}, 0);
    pin_n[1] <= 1'b0;
    tick(6);
    wr(0, 32'h0000_0015);
    await(20, 1);
    wr(0, 32'h0000_0025);
    tick(24);
    chk("hold command", batch_running_o, 0);
    wr(0, 32'h0000_0015);
    await(20, 1);
    pulse(3);
    chk("rewound", batch_running_o, 0);
    wr(0, 32'h0000_0015);
    await(20, 1);
    wr(0, 32'h0000_0085);
    tick(4);
    chk("stop command", batch_running_o, 0);
    wr(0, 32'h0000_0045);
    rd(4);
    chk("rewind command", {rdata_o[9:5], rdata_o[1:0]}, 0);
    rd(1936);
    chk("unmapped", rdata_o, 0);
    summarize;
  end
endmodule // setpoint_batch_sequencer_tb
